// ===== qps_pkg.sv
// Constants and types shared by the quad potentiometer serial control block.
// ---------------------------------------------------------------------------
// Notes on behaviour
// RQ1: Serial input sampled on rising clock edge.
// RQ2: Serial output changes on falling clock edge.
// RQ3: Link works in modes (0,0) and (1,1).
// RQ4: Respond only when device address matches straps.
// RQ5: Select high: output floats, device idles.
// RQ6: Decoding starts only after select falls.
// RQ7: Select rising after valid write commits it.
// RQ8: Protect low blocks saved writes, wipers allowed.
// RQ9: Protect falling mid-frame abandons pending write.
// RQ10: Started write cycle ignores later protect changes.
// RQ11: Pause holds place, floats output, ignores input.
// RQ12: Pause release resumes sequence where it stopped.
// RQ13: Instruction shifts into eight-bit register.
// RQ14: First byte chooses one of six operations.
// RQ15: Four wiper and sixteen saved six-bit registers.
// RQ16: Exactly one tap per potentiometer is selected; reset holds all taps off until the first clock after it.
// RQ17: Power-up copies first saved setting to wiper.
// RQ18: Master reads and writes both register kinds.
// RQ19: Transfers between wiper and saved; stepping mode.
// RQ20: Unknown opcodes ignored until select rises.
// ---------------------------------------------------------------------------
package qps_pkg;

    // Array sizes and field widths.
    localparam int QPS_NUM_POTS = 4;
    localparam int QPS_NUM_SAVED = 4;
    localparam int QPS_POS_W = 6;
    localparam int QPS_BYTE_W = 8;
    localparam int QPS_TAPS = 64;
    localparam int QPS_BUSY_W = 16;

    // Wiper limits, saved reset value and last bit of a byte.
    localparam logic [5:0] QPS_POS_MAX = 6'h3F;
    localparam logic [5:0] QPS_POS_MIN = 6'h00;
    localparam logic [5:0] QPS_SAVED_RESET = 6'h20;
    localparam logic [2:0] QPS_LAST_BIT = 3'h7;
    localparam logic [1:0] QPS_FIRST_SAVED = 2'h0;

    // Default operation codes of the six instructions.
    localparam logic [7:0] QPS_OPC_READ_WIPER = 8'h90;
    localparam logic [7:0] QPS_OPC_WRITE_WIPER = 8'hA0;
    localparam logic [7:0] QPS_OPC_READ_SAVED = 8'hB0;
    localparam logic [7:0] QPS_OPC_WRITE_SAVED = 8'hC0;
    localparam logic [7:0] QPS_OPC_TRANSFER = 8'hD0;
    localparam logic [7:0] QPS_OPC_STEP = 8'h20;

    // Nonvolatile write time and system clock period.
    localparam int QPS_NV_WRITE_NS = 5000;
    localparam int QPS_CLK_PERIOD_NS = 25;

    // Frame phases of the serial decoder, Gray along the usual path.
    typedef enum logic [1:0] {
        QPS_PH_OPCODE = 2'b00,
        QPS_PH_ADDRESS = 2'b01,
        QPS_PH_DATA = 2'b11,
        QPS_PH_IGNORE = 2'b10
    } qps_phase_type;

    // Kinds of committed commands.
    typedef enum logic [2:0] {
        QPS_K_WRITE_WIPER = 3'h0,
        QPS_K_WRITE_SAVED = 3'h1,
        QPS_K_SAVE_WIPER = 3'h2,
        QPS_K_RECALL = 3'h3,
        QPS_K_STEP = 3'h4
    } qps_kind_type;

    // Layout of the address byte.
    typedef struct packed {
        logic [1:0] device;
        logic recall;
        logic spare;
        logic [1:0] index;
        logic [1:0] pot;
    } qps_addr_type;

    // Command handed from the link to the register side.
    typedef struct packed {
        qps_kind_type kind;
        logic [1:0] pot;
        logic [1:0] index;
        logic [5:0] value;
    } qps_cmd_type;

endpackage : qps_pkg

// ===== qps_spi_control.sv
// Serial slave control logic of the quad digital potentiometer.
`timescale 1ns/100ps

module qps_spi_control #(
    parameter logic [7:0] OPC_READ_WIPER = qps_pkg::QPS_OPC_READ_WIPER,
    parameter logic [7:0] OPC_WRITE_WIPER = qps_pkg::QPS_OPC_WRITE_WIPER,
    parameter logic [7:0] OPC_READ_SAVED = qps_pkg::QPS_OPC_READ_SAVED,
    parameter logic [7:0] OPC_WRITE_SAVED = qps_pkg::QPS_OPC_WRITE_SAVED,
    parameter logic [7:0] OPC_TRANSFER = qps_pkg::QPS_OPC_TRANSFER,
    parameter logic [7:0] OPC_STEP = qps_pkg::QPS_OPC_STEP,
    parameter int NV_WRITE_NS = qps_pkg::QPS_NV_WRITE_NS
) (
    // System clock and power-up reset.
    input wire logic clk_in,
    input wire logic sys_rst_in,
    // Serial link pins.
    input wire logic sck_in,
    input wire logic cs_n_in,
    input wire logic si_in,
    input wire logic pause_n_in,
    output logic so_out,
    output logic so_oe_out,
    // Address straps and write protect.
    input wire logic address_select_low_in,
    input wire logic address_select_high_in,
    input wire logic wp_n_in,
    // Tap selection and status.
    output logic [qps_pkg::QPS_NUM_POTS-1:0][qps_pkg::QPS_TAPS-1:0] tap_select_out,
    output logic nv_write_busy_out
);
    import qps_pkg::*;

    // -----------------------------------------------------------------------
    // Constants and functions
    // -----------------------------------------------------------------------

    // Nonvolatile write time in system clock cycles, rounded up.
    localparam int NV_WRITE_CYCLES = (NV_WRITE_NS + QPS_CLK_PERIOD_NS - 1) / QPS_CLK_PERIOD_NS;
    localparam logic [QPS_BUSY_W-1:0] NV_CYCLES_CNT = QPS_BUSY_W'(NV_WRITE_CYCLES);

    // True when the byte is one of the six operation codes.
    function automatic logic opcode_known(input logic [QPS_BYTE_W-1:0] code);
        return (code == OPC_READ_WIPER) || (code == OPC_WRITE_WIPER) ||
               (code == OPC_READ_SAVED) || (code == OPC_WRITE_SAVED) ||
               (code == OPC_TRANSFER) || (code == OPC_STEP);
    endfunction : opcode_known

    // One stepping move, saturating at both ends of the tap range.
    function automatic logic [QPS_POS_W-1:0] step_value(input logic [QPS_POS_W-1:0] pos,
                                                         input logic up);
        logic [QPS_POS_W-1:0] result;
        result = pos;
        if (up && (pos != QPS_POS_MAX)) begin
            result = pos + 1'b1;
        end else if (!up && (pos != QPS_POS_MIN)) begin
            result = pos - 1'b1;
        end
        return result;
    endfunction : step_value

    // One-hot tap selection from a wiper position.
    function automatic logic [QPS_TAPS-1:0] tap_decode(input logic [QPS_POS_W-1:0] pos);
        logic [QPS_TAPS-1:0] onehot;
        onehot = '0;
        onehot[pos] = 1'b1;
        return onehot;
    endfunction : tap_decode

    // -----------------------------------------------------------------------
    // Declarations
    // -----------------------------------------------------------------------

    // Frame reset of the link logic: power-up or deselect.
    logic link_rst;

    // Link-side frame state, cleared whenever select is high.
    qps_phase_type phase_reg, phase_next;
    logic [2:0] bit_cnt_reg, bit_cnt_next;
    logic [QPS_BYTE_W-2:0] shift_reg, shift_next;
    logic [QPS_BYTE_W-1:0] instr_reg, instr_next;
    qps_addr_type addr_reg, addr_next;

    // Link-side command hand-over, survives deselect.
    qps_cmd_type cmd_reg, cmd_next;
    logic toggle_reg, toggle_next;

    // Falling-edge serial output stage.
    logic so_reg, so_next;

    // Link-side decode helpers.
    logic [QPS_BYTE_W-1:0] byte_in;
    qps_addr_type addr_in;
    logic byte_done;
    logic reading;
    logic [QPS_POS_W-1:0] read_value;
    logic [QPS_BYTE_W-1:0] read_byte;

    // System-side synchronisers.
    logic cs_meta_reg, cs_sync_reg, cs_prev_reg;
    logic wp_meta_reg, wp_sync_reg, wp_prev_reg;
    logic [1:0] strap_meta_reg, strap_sync_reg;

    // System-side register file and control.
    logic [QPS_NUM_POTS-1:0][QPS_POS_W-1:0] wiper_reg, wiper_next;
    logic [QPS_NUM_POTS-1:0][QPS_NUM_SAVED-1:0][QPS_POS_W-1:0] saved_reg, saved_next;
    logic [QPS_NUM_POTS-1:0][QPS_TAPS-1:0] tap_reg, tap_next;
    logic seen_reg, seen_next;
    logic wp_fell_reg, wp_fell_next;
    logic load_pending_reg, load_pending_next;
    logic [QPS_BUSY_W-1:0] busy_cnt_reg, busy_cnt_next;
    logic busy_reg, busy_next;

    // System-side event helpers.
    logic cs_rise, cs_fall, wp_fall, commit, nv_ok;

    // -----------------------------------------------------------------------
    // Link domain: frame decoder on the serial clock
    // -----------------------------------------------------------------------

    // A high select holds the frame logic in reset, so each frame starts clean.
    assign link_rst = sys_rst_in | cs_n_in; // [RQ6]

    // Output floats while deselected or paused. [RQ5] [RQ11]
    assign so_oe_out = ~cs_n_in & pause_n_in;
    assign so_out = so_reg;

    // Read source: wiper or saved register named by the address byte.
    // The register side only changes these while select is high, so they
    // stand still for the whole of a frame.
    always_comb begin
        reading = (instr_reg == OPC_READ_WIPER) || (instr_reg == OPC_READ_SAVED);
        if (instr_reg == OPC_READ_WIPER) begin
            read_value = wiper_reg[addr_reg.pot]; // [RQ18]
        end else begin
            read_value = saved_reg[addr_reg.pot][addr_reg.index]; // [RQ18]
        end
        read_byte = {{(QPS_BYTE_W - QPS_POS_W){1'b0}}, read_value};
    end

    // Next-state decode of the frame: opcode byte, address byte, data.
    always_comb begin
        byte_in = {shift_reg, si_in}; // [RQ1]
        addr_in = qps_addr_type'(byte_in);
        byte_done = (bit_cnt_reg == QPS_LAST_BIT);
        phase_next = phase_reg;
        bit_cnt_next = bit_cnt_reg;
        shift_next = shift_reg;
        instr_next = instr_reg;
        addr_next = addr_reg;
        cmd_next = cmd_reg;
        toggle_next = toggle_reg;
        // A paused link ignores its input and keeps its place. [RQ11] [RQ12]
        if (pause_n_in) begin
            bit_cnt_next = bit_cnt_reg + 1'b1;
            shift_next = byte_in[QPS_BYTE_W-2:0];
            unique case (phase_reg)
                // First byte selects the operation. [RQ13] [RQ14]
                QPS_PH_OPCODE: begin
                    if (byte_done) begin
                        instr_next = byte_in;
                        // Unknown codes park the frame until deselect. [RQ20]
                        phase_next = opcode_known(byte_in) ? QPS_PH_ADDRESS : QPS_PH_IGNORE;
                    end
                end
                // Second byte names device, register and potentiometer.
                QPS_PH_ADDRESS: begin
                    if (byte_done) begin
                        addr_next = addr_in;
                        if (addr_in.device != strap_sync_reg) begin
                            phase_next = QPS_PH_IGNORE; // [RQ4]
                        end else if (instr_reg == OPC_TRANSFER) begin
                            // Transfer needs no data byte. [RQ19]
                            cmd_next.kind = addr_in.recall ? QPS_K_RECALL : QPS_K_SAVE_WIPER;
                            cmd_next.pot = addr_in.pot;
                            cmd_next.index = addr_in.index;
                            cmd_next.value = QPS_POS_MIN;
                            toggle_next = ~toggle_reg;
                            phase_next = QPS_PH_IGNORE;
                        end else if (instr_reg == OPC_STEP) begin
                            // Stepping starts from the present wiper. [RQ19]
                            cmd_next.kind = QPS_K_STEP;
                            cmd_next.pot = addr_in.pot;
                            cmd_next.index = addr_in.index;
                            cmd_next.value = wiper_reg[addr_in.pot];
                            toggle_next = ~toggle_reg;
                            phase_next = QPS_PH_DATA;
                        end else begin
                            phase_next = QPS_PH_DATA;
                        end
                    end
                end
                // Data byte, read byte, or a run of stepping bits.
                QPS_PH_DATA: begin
                    if (instr_reg == OPC_STEP) begin
                        // Each bit moves the wiper one tap: one up, zero down.
                        cmd_next.value = step_value(cmd_reg.value, si_in); // [RQ19]
                    end else if (byte_done) begin
                        phase_next = QPS_PH_IGNORE;
                        if ((instr_reg == OPC_WRITE_WIPER) || (instr_reg == OPC_WRITE_SAVED)) begin
                            // A complete write byte becomes a pending command. [RQ18]
                            cmd_next.kind = (instr_reg == OPC_WRITE_WIPER) ?
                                            QPS_K_WRITE_WIPER : QPS_K_WRITE_SAVED;
                            cmd_next.pot = addr_reg.pot;
                            cmd_next.index = addr_reg.index;
                            cmd_next.value = byte_in[QPS_POS_W-1:0];
                            toggle_next = ~toggle_reg;
                        end
                    end
                end
                // Everything after the sequence is ignored.
                QPS_PH_IGNORE: begin
                    phase_next = QPS_PH_IGNORE;
                end
            endcase
        end
    end

    // Frame registers, sampled on the rising serial clock edge. [RQ1] [RQ3]
    always_ff @(posedge sck_in or posedge link_rst) begin
        if (link_rst) begin
            phase_reg <= QPS_PH_OPCODE;
            bit_cnt_reg <= '0;
            shift_reg <= '0;
            instr_reg <= '0;
            addr_reg <= '0;
        end else begin
            phase_reg <= phase_next;
            bit_cnt_reg <= bit_cnt_next;
            shift_reg <= shift_next;
            instr_reg <= instr_next;
            addr_reg <= addr_next;
        end
    end

    // Command registers must outlive the frame so the register side can
    // take them after select rises; only power-up clears them.
    always_ff @(posedge sck_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            cmd_reg <= '0;
            toggle_reg <= 1'b0;
        end else begin
            cmd_reg <= cmd_next;
            toggle_reg <= toggle_next;
        end
    end

    // Output bit for the next falling edge, most significant bit first.
    always_comb begin
        so_next = so_reg;
        if (pause_n_in) begin
            so_next = ((phase_reg == QPS_PH_DATA) && reading) ? read_byte[~bit_cnt_reg] : 1'b0;
        end
    end

    // Serial output register, updated on the falling edge. [RQ2] [RQ3]
    always_ff @(negedge sck_in or posedge link_rst) begin
        if (link_rst) begin
            so_reg <= 1'b0;
        end else begin
            so_reg <= so_next;
        end
    end

    // -----------------------------------------------------------------------
    // System domain: synchronisers
    // -----------------------------------------------------------------------

    // Two-flop synchronisers for select, protect and the address straps.
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            cs_meta_reg <= 1'b1;
            cs_sync_reg <= 1'b1;
            cs_prev_reg <= 1'b1;
            wp_meta_reg <= 1'b1;
            wp_sync_reg <= 1'b1;
            wp_prev_reg <= 1'b1;
            strap_meta_reg <= '0;
            strap_sync_reg <= '0;
        end else begin
            cs_meta_reg <= cs_n_in;
            cs_sync_reg <= cs_meta_reg;
            cs_prev_reg <= cs_sync_reg;
            wp_meta_reg <= wp_n_in;
            wp_sync_reg <= wp_meta_reg;
            wp_prev_reg <= wp_sync_reg;
            strap_meta_reg <= {address_select_high_in, address_select_low_in};
            strap_sync_reg <= strap_meta_reg;
        end
    end

    // -----------------------------------------------------------------------
    // System domain: register file and commit
    // -----------------------------------------------------------------------

    // Edge events and the commit decision.
    always_comb begin
        cs_rise = cs_sync_reg & ~cs_prev_reg;
        cs_fall = ~cs_sync_reg & cs_prev_reg;
        wp_fall = ~wp_sync_reg & wp_prev_reg;
        // The link is quiet once select is high, so the command is stable.
        commit = cs_rise && (toggle_reg != seen_reg) && !wp_fell_reg; // [RQ7] [RQ9]
        // Saved writes need protect high and no cycle under way.
        nv_ok = wp_sync_reg && (busy_cnt_reg == '0); // [RQ8]
    end

    // Next values of the register file, protect tracking and write timer.
    always_comb begin
        wiper_next = wiper_reg;
        saved_next = saved_reg;
        seen_next = seen_reg;
        wp_fell_next = wp_fell_reg;
        load_pending_next = 1'b0;
        busy_cnt_next = busy_cnt_reg;
        // A running write cycle counts down whatever protect does. [RQ10]
        if (busy_cnt_reg != '0) begin
            busy_cnt_next = busy_cnt_reg - 1'b1;
        end
        // Protect falling inside a frame marks it; the set wins. [RQ9]
        if (cs_fall) begin
            wp_fell_next = 1'b0;
        end
        if (wp_fall && !cs_sync_reg) begin
            wp_fell_next = 1'b1;
        end
        // Power-up recall of the first saved setting. [RQ17]
        if (load_pending_reg) begin
            for (int p = 0; p < QPS_NUM_POTS; p++) begin
                wiper_next[p] = saved_reg[p][QPS_FIRST_SAVED];
            end
        end
        // Every rising select consumes whatever command is pending.
        if (cs_rise) begin
            seen_next = toggle_reg;
        end
        if (commit) begin
            unique case (cmd_reg.kind)
                // Wiper writes pass even with protect low. [RQ8] [RQ18]
                QPS_K_WRITE_WIPER, QPS_K_STEP: begin
                    wiper_next[cmd_reg.pot] = cmd_reg.value;
                end
                // Saved setting copied into the wiper. [RQ19]
                QPS_K_RECALL: begin
                    wiper_next[cmd_reg.pot] = saved_reg[cmd_reg.pot][cmd_reg.index];
                end
                // Nonvolatile write of a data byte. [RQ8] [RQ15]
                QPS_K_WRITE_SAVED: begin
                    if (nv_ok) begin
                        saved_next[cmd_reg.pot][cmd_reg.index] = cmd_reg.value;
                        busy_cnt_next = NV_CYCLES_CNT;
                    end
                end
                // Nonvolatile save of the present wiper. [RQ19]
                QPS_K_SAVE_WIPER: begin
                    if (nv_ok) begin
                        saved_next[cmd_reg.pot][cmd_reg.index] = wiper_reg[cmd_reg.pot];
                        busy_cnt_next = NV_CYCLES_CNT;
                    end
                end
                // Codes outside the kinds leave everything alone.
                default: begin
                    seen_next = toggle_reg;
                end
            endcase
        end
        busy_next = (busy_cnt_next != '0);
    end

    // One-hot tap selection per potentiometer. [RQ16]
    always_comb begin
        for (int p = 0; p < QPS_NUM_POTS; p++) begin
            tap_next[p] = tap_decode(wiper_reg[p]);
        end
    end

    // Register file, timers and flags. Saved settings take their reset
    // value at power-up and the wipers pick them up one cycle later.
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            wiper_reg <= '0;
            saved_reg <= {(QPS_NUM_POTS * QPS_NUM_SAVED){QPS_SAVED_RESET}};
            tap_reg <= '0;
            seen_reg <= 1'b0;
            wp_fell_reg <= 1'b0;
            load_pending_reg <= 1'b1;
            busy_cnt_reg <= '0;
            busy_reg <= 1'b0;
        end else begin
            wiper_reg <= wiper_next;
            saved_reg <= saved_next;
            tap_reg <= tap_next;
            seen_reg <= seen_next;
            wp_fell_reg <= wp_fell_next;
            load_pending_reg <= load_pending_next;
            busy_cnt_reg <= busy_cnt_next;
            busy_reg <= busy_next;
        end
    end

    // Registered status outputs.
    assign tap_select_out = tap_reg;
    assign nv_write_busy_out = busy_reg;

endmodule : qps_spi_control

// ===== qps_spi_control_sva.sv
// Port checker of the quad potentiometer serial control block.
`timescale 1ns/100ps
module qps_spi_control_sva #(
    parameter int NV_WRITE_NS = 5000
) (
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire logic cs_n_in,
    input wire logic pause_n_in,
    input wire logic wp_n_in,
    input logic so_out,
    input logic so_oe_out,
    input logic [qps_pkg::QPS_NUM_POTS-1:0][qps_pkg::QPS_TAPS-1:0] tap_select_out,
    input logic nv_write_busy_out
);
    import qps_pkg::*;
    localparam int BUSY_N = (NV_WRITE_NS + QPS_CLK_PERIOD_NS - 1) / QPS_CLK_PERIOD_NS;
    logic [1:0] age_reg; // Cycles since reset, saturating.
    logic [1:0] age_next;
    int busy_reg; // Length of the running busy pulse.
    int busy_next;
    always_comb begin
        age_next = (age_reg == 2'h3) ? age_reg : age_reg + 2'h1;
        busy_next = nv_write_busy_out ? busy_reg + 1 : 0;
    end
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            age_reg <= 2'h0;
            busy_reg <= 0;
        end else begin
            age_reg <= age_next;
            busy_reg <= busy_next;
        end
    end
    default clocking @(posedge clk_in); endclocking
    default disable iff (sys_rst_in);
    oe_idle_a: assert property (cs_n_in |-> !so_oe_out) else $error("so driven");
    pause_float_a: assert property (!pause_n_in |-> !so_oe_out) else $error("so on");
    so_quiet_a: assert property (cs_n_in |-> !so_out) else $error("so high idle");
    tap_onehot_a: assert property (age_reg == 2'h3 |-> $onehot(tap_select_out[0])
        && $onehot(tap_select_out[1]) && $onehot(tap_select_out[2])
        && $onehot(tap_select_out[3])) else $error("tap not one-hot");
    power_recall_a: assert property (age_reg == 2'h2 |-> tap_select_out[3][32]
        && tap_select_out[0][32]) else $error("no recall");
    tap_change_a: assert property (age_reg == 2'h3 && !$stable(tap_select_out)
        |-> cs_n_in) else $error("tap moved in frame");
    busy_cs_a: assert property ($rose(nv_write_busy_out) |-> cs_n_in) else $error("early");
    busy_wp_a: assert property ($rose(nv_write_busy_out) |-> $past(wp_n_in, 3))
        else $error("wp");
    busy_len_a: assert property ($fell(nv_write_busy_out) |-> busy_reg == BUSY_N)
        else $error("busy length");
    busy_c: cover property ($rose(nv_write_busy_out));
    pause_c: cover property (!pause_n_in && !cs_n_in);
    tap_c: cover property (age_reg == 2'h3 && !$stable(tap_select_out));
endmodule : qps_spi_control_sva
bind qps_spi_control qps_spi_control_sva #(.NV_WRITE_NS(NV_WRITE_NS)) qps_spi_control_sva_inst (
    .clk_in(clk_in), .sys_rst_in(sys_rst_in), .cs_n_in(cs_n_in), .pause_n_in(pause_n_in),
    .wp_n_in(wp_n_in), .so_out(so_out), .so_oe_out(so_oe_out),
    .tap_select_out(tap_select_out), .nv_write_busy_out(nv_write_busy_out));

// ===== qps_spi_master.sv
// Serial link master model that drives the potentiometer control block.
`timescale 1ns/100ps
module qps_spi_master (
    // Link pins.
    output logic sck_out,
    output logic cs_n_out,
    output logic si_out,
    output logic pause_n_out,
    input wire logic so_in
);
    initial begin
        sck_out = 1'b0;
        cs_n_out = 1'b1;
        si_out = 1'b0;
        pause_n_out = 1'b1;
    end
    // Sends n bits MSB first in mode (m,m); pauses before bit p.
    task xfer(input logic [31:0] b, input int n, input logic m, input int p,
              output logic [7:0] rd);
        sck_out = m;
        #80 cs_n_out = 1'b0;
        #80;
        for (int i = n - 1; i >= 0; i--) begin
            sck_out = 1'b0;
            if (i == p) begin
                pause_n_out = 1'b0; // Pause only while the clock is low.
                repeat (4) #50 si_out = ~si_out;
                pause_n_out = 1'b1; // Resume while the clock is low.
            end
            si_out = b[i];
            #80 sck_out = 1'b1;
            rd = {rd[6:0], so_in};
            #80;
        end
        sck_out = m;
        si_out = ~si_out; // A released line shows no stale value.
        #80 cs_n_out = 1'b1;
        #1000;
    endtask : xfer
endmodule : qps_spi_master

// ===== test_quad_pot_spi_control.sv
// Testbench of the quad potentiometer serial control block.
`timescale 1ns/100ps
module test_quad_pot_spi_control;
    import qps_pkg::*;
    logic clk_in = 1'b0;
    logic sys_rst_in = 1'b1;
    logic wp_n_in = 1'b1;
    logic sck, cs_n, si, pause_n, so_out, so_oe_out, busy;
    logic [QPS_NUM_POTS-1:0][QPS_TAPS-1:0] tap;
    logic [7:0] rd;
    int num_errors = 0;
    int samples_checked = 0;
    wire so_line = so_oe_out ? so_out : ~so_out;
    always #12.5 clk_in = ~clk_in;
    qps_spi_control #(.NV_WRITE_NS(100)) qps_spi_control_inst (.clk_in(clk_in),
        .sys_rst_in(sys_rst_in), .sck_in(sck), .cs_n_in(cs_n), .si_in(si),
        .pause_n_in(pause_n), .so_out(so_out), .so_oe_out(so_oe_out),
        .address_select_low_in(1'b1), .address_select_high_in(1'b0), .wp_n_in(wp_n_in),
        .tap_select_out(tap), .nv_write_busy_out(busy));
    qps_spi_master qps_spi_master_inst (.sck_out(sck), .cs_n_out(cs_n), .si_out(si),
        .pause_n_out(pause_n), .so_in(so_line));
    task check(input logic [63:0] seen, input logic [63:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check
    // Address byte of this device (straps give 2'h1).
    function logic [7:0] ad(input logic [1:0] pot, input logic [1:0] idx, input logic rc);
        return {2'h1, rc, 1'b0, idx, pot};
    endfunction : ad
    task frame(input logic [7:0] op, input logic [7:0] a, input logic [7:0] d,
               input int n, input logic m, input int p);
        @(negedge clk_in);
        qps_spi_master_inst.xfer({8'h00, op, a, d} >> (24 - n), n, m, p, rd);
        @(negedge clk_in);
    endtask : frame
    task print_verdict();
        $display("Checks %0d errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : print_verdict
    initial begin
        #1000000;
        num_errors++;
        print_verdict();
    end
    initial begin
        repeat (12) @(posedge clk_in);
        @(negedge clk_in) sys_rst_in = 1'b0;
        repeat (4) @(negedge clk_in);
        for (int p = 0; p < 4; p++) check(tap[p], 64'h1 << 32);
        for (int p = 0; p < 4; p++) begin
            frame(QPS_OPC_WRITE_WIPER, ad(2'(p), 2'h0, 1'b0), 8'(p * 21), 24, p[0],
                  (p == 2) ? 12 : -1);
            check(tap[p], 64'h1 << (p * 21));
        end
        frame(QPS_OPC_READ_WIPER, ad(2'h2, 2'h0, 1'b0), 8'h00, 24, 1'b1, -1);
        check(rd, 8'h2A);
        frame(QPS_OPC_WRITE_WIPER, ad(2'h0, 2'h0, 1'b0) ^ 8'hC0, 8'h07, 24, 1'b0, -1);
        frame(8'h55, ad(2'h0, 2'h0, 1'b0), 8'h07, 24, 1'b0, -1);
        frame(QPS_OPC_WRITE_WIPER, ad(2'h0, 2'h0, 1'b0), 8'h07, 20, 1'b0, -1);
        check(tap[0], 64'h1);
        frame(QPS_OPC_WRITE_SAVED, ad(2'h1, 2'h2, 1'b0), 8'h11, 24, 1'b0, -1);
        wp_n_in = 1'b0;
        frame(QPS_OPC_WRITE_SAVED, ad(2'h1, 2'h2, 1'b0), 8'h22, 24, 1'b0, -1);
        frame(QPS_OPC_WRITE_WIPER, ad(2'h1, 2'h0, 1'b0), 8'h05, 24, 1'b0, -1);
        check(tap[1], 64'h1 << 5);
        frame(QPS_OPC_READ_SAVED, ad(2'h1, 2'h2, 1'b0), 8'h00, 24, 1'b0, -1);
        check(rd, 8'h11);
        wp_n_in = 1'b1;
        fork
            frame(QPS_OPC_WRITE_WIPER, ad(2'h1, 2'h0, 1'b0), 8'h09, 24, 1'b0, -1);
            #2000 wp_n_in = 1'b0;
        join
        check(tap[1], 64'h1 << 5);
        wp_n_in = 1'b1;
        fork
            frame(QPS_OPC_WRITE_SAVED, ad(2'h0, 2'h3, 1'b0), 8'h2A, 24, 1'b0, -1);
            @(posedge busy) @(negedge clk_in) wp_n_in = 1'b0;
        join
        wp_n_in = 1'b1;
        frame(QPS_OPC_READ_SAVED, ad(2'h0, 2'h3, 1'b0), 8'h00, 24, 1'b0, -1);
        check(rd, 8'h2A);
        frame(QPS_OPC_TRANSFER, ad(2'h1, 2'h2, 1'b1), 8'h00, 16, 1'b0, -1);
        check(tap[1], 64'h1 << 6'h11);
        frame(QPS_OPC_TRANSFER, ad(2'h3, 2'h1, 1'b0), 8'h00, 16, 1'b0, -1);
        frame(QPS_OPC_STEP, ad(2'h3, 2'h0, 1'b0), 8'hFF, 24, 1'b0, -1);
        check(tap[3], 64'h1 << 63);
        frame(QPS_OPC_STEP, ad(2'h3, 2'h0, 1'b0), 8'h00, 24, 1'b1, -1);
        check(tap[3], 64'h1 << 55);
        frame(QPS_OPC_READ_SAVED, ad(2'h3, 2'h1, 1'b0), 8'h00, 24, 1'b0, -1);
        check(rd, 8'h3F);
        print_verdict();
    end
endmodule : test_quad_pot_spi_control
